// ===== design/mfr_defs.svh
/*
  Constants for the motor fault and regeneration control block: register
  offsets, fixed thresholds as bus-sense codes, conversion factors and times.
  Assumes a 10-bit sense code where full scale is 5 V and a 100 MHz core clock.
*/
`ifndef MFR_DEFS_SVH
`define MFR_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define MFR_OFS_CTRL 8'h00
`define MFR_OFS_BOOST 8'h04
`define MFR_OFS_RETRY 8'h08
`define MFR_OFS_BUS_HI 8'h0c
`define MFR_OFS_BUS_LO 8'h10
`define MFR_OFS_BRAKE 8'h14
`define MFR_OFS_ONSET 8'h18
`define MFR_OFS_VOVR 8'h1c
`define MFR_OFS_STATUS 8'h20
`define MFR_OFS_SAMPLE 8'h24

// ----------------------------------------------------------------------------
// fixed standalone levels, codes of 5 V / 1024
// ----------------------------------------------------------------------------
`define MFR_CODE_BUS_HI 10'h393
`define MFR_CODE_BUS_LO 10'h166
`define MFR_CODE_BRAKE 10'h314
`define MFR_CODE_ONSET 10'h314
`define MFR_CODE_SPAN 10'h07f
`define MFR_SPAN_RECIP 16'h0204

// ----------------------------------------------------------------------------
// boost, retry and base-frequency scaling
// ----------------------------------------------------------------------------
`define MFR_BOOST_PCT_PER_FS 16'h0028
`define MFR_BOOST_PCT_MAX 7'h28
`define MFR_BOOST_PCT_HOST_MAX 7'h64
`define MFR_PCT_TO_Q16 10'h28f
`define MFR_RETRY_Q_PER_FS 18'h000f0
`define MFR_RETRY_Q_MIN 16'h0004
`define MFR_RETRY_Q_HOST_MIN 16'h0001
`define MFR_RECIP_50HZ 13'h147b
`define MFR_RECIP_60HZ 13'h1111

// ----------------------------------------------------------------------------
// times
// ----------------------------------------------------------------------------
`define MFR_CLK_HZ 100000000
`define MFR_CLK_NS 10
`define MFR_SAMPLE_HZ_FAST 5300
`define MFR_SAMPLE_HZ_SLOW 4000
`define MFR_RETRY_TICK_MS 250
`define MFR_LOSTCLK_NS 10000
`define MFR_SETTLE_NS 1000

`endif

// ===== design/mfr_pkg.sv
/*
  Types for the motor fault and regeneration control block.
  Assumes mfr_defs.svh supplies the numeric constants.
*/
package mfr_pkg;

  // --------------------------------------------------------------------------
  // controller phases
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STRAP,
    ST_BOOST,
    ST_RETRY,
    ST_UVWAIT,
    ST_RUN
  } mfr_state_t;

  // --------------------------------------------------------------------------
  // effective configuration
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] boost_pct;
    logic [15:0] retry_q;
    logic [9:0] bus_hi;
    logic [9:0] bus_lo;
    logic [9:0] brake_thr;
    logic [9:0] onset_thr;
  } mfr_cfg_t;

endpackage : mfr_pkg

// ===== design/mfr_top.sv
/*
  Fault handling, voltage profile and regeneration control of a three-phase
  open-loop motor controller, with an APB register slave.
  Assumes bus and parameter sense codes arrive from an ADC on CORE_CLK;
  fault, reference clock and strobe pins are asynchronous.
*/
// Function
// R1: strobe pin high after reset selects standalone, else hosted mode.
// R2: standalone reads boost from sense input while driving boost strobe low.
// R3: standalone boost is 8 percent per volt, 0 to 40 percent.
// R4: hosted boost settable 0 to 100 percent at any time.
// R5: output amplitude follows boost, base frequency and waveform frequency.
// R6: hosted mode may override amplitude in real time.
// R7: any fault disables PWM at once; retry timer starts after clearing.
// R8: standalone reads retry time while driving retry strobe low.
// R9: standalone retry is 12 seconds per volt, 1 to 60 seconds.
// R10: hosted retry settable 0.25 second to over 4.5 hours.
// R11: external fault high disables PWM without waiting for sampling.
// R12: external fault low starts retry; PWM returns after timeout.
// R13: lost reference clock disables PWM and restarts the controller.
// R14: bus sampled at 5.3 kHz, 4.0 kHz with 15.9 kHz PWM.
// R15: standalone bus window 1.75 to 4.47 volts, else fault.
// R16: hosted upper and lower bus thresholds set independently.
// R17: bus back inside window starts retry; PWM returns after timeout.
// R18: standalone start waits for bus above undervoltage level.
// R19: standalone brake output high from 3.85 volts bus.
// R20: hosted brake and decel onset thresholds settable any time.
// R21: deceleration uses the acceleration rate unless limited.
// R22: above onset decel rate drops, zero at 0.62 volts above.
// R23: standalone decel onset fixed at 3.85 volts.
// R24: decel rate falls linearly across the limiting span.
// R25: brake output low again once bus falls below threshold.
`timescale 1ns/1ps
`include "mfr_defs.svh"

module mfr_top
  import mfr_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV_FAST = `MFR_CLK_HZ / `MFR_SAMPLE_HZ_FAST,
  parameter int unsigned SAMPLE_DIV_SLOW = `MFR_CLK_HZ / `MFR_SAMPLE_HZ_SLOW,
  parameter int unsigned RETRY_TICK_CYCLES = (`MFR_CLK_HZ / 1000) * `MFR_RETRY_TICK_MS,
  parameter int unsigned LOSTCLK_CYCLES = `MFR_LOSTCLK_NS / `MFR_CLK_NS,
  parameter int unsigned SETTLE_CYCLES = (`MFR_SETTLE_NS + `MFR_CLK_NS - 1) / `MFR_CLK_NS
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BOOST_SELECT_STROBE_I,
  output logic BOOST_SELECT_STROBE_O,
  output logic BOOST_SELECT_STROBE_OE,
  output logic RETRY_SELECT_STROBE_N,
  input wire logic [9:0] PARAM_SENSE,
  input wire logic [9:0] BUS_VOLTAGE_SENSE,
  input wire logic EXTERNAL_FAULT_INPUT,
  input wire logic REFERENCE_CLOCK_INPUT,
  input wire logic PWM_FREQ_15K9,
  input wire logic BASE_FREQ_60,
  input wire logic [15:0] WAVE_FREQ,
  input wire logic DECELERATING,
  input wire logic [15:0] ACCEL_RATE,
  output logic PWM_ENABLE,
  output logic BRAKE_DRIVE_OUTPUT,
  output logic [15:0] VOLT_AMPLITUDE,
  output logic [15:0] DECEL_RATE,
  output logic STANDALONE
);

  // --------------------------------------------------------------------------
  // pin synchronisers: 0 fault, 1 reference clock, 2 boost strobe
  // --------------------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] filt_reg;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      filt_reg <= 3'h0;
    end else begin
      sync1_reg <= {BOOST_SELECT_STROBE_I, REFERENCE_CLOCK_INPUT, EXTERNAL_FAULT_INPUT};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // --------------------------------------------------------------------------
  // lost reference clock watchdog
  // --------------------------------------------------------------------------
  logic [31:0] lost_cnt_reg;
  logic ref_prev_reg;
  logic lost_now;

  assign lost_now = (lost_cnt_reg >= LOSTCLK_CYCLES);

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lost_cnt_reg <= 32'h0;
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= filt_reg[1];
      if (filt_reg[1] != ref_prev_reg || lost_now) begin
        lost_cnt_reg <= 32'h0;
      end else begin
        lost_cnt_reg <= lost_cnt_reg + 32'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // bus sample divider
  // --------------------------------------------------------------------------
  logic [31:0] smp_cnt_reg;
  logic sample_tick;
  logic [31:0] smp_div;

  assign smp_div = PWM_FREQ_15K9 ? SAMPLE_DIV_SLOW : SAMPLE_DIV_FAST; // [R14]
  assign sample_tick = (smp_cnt_reg >= smp_div - 32'h1);

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      smp_cnt_reg <= 32'h0;
    end else if (sample_tick) begin
      smp_cnt_reg <= 32'h0;
    end else begin
      smp_cnt_reg <= smp_cnt_reg + 32'h1;
    end
  end

  // --------------------------------------------------------------------------
  // startup sequence
  // --------------------------------------------------------------------------
  mfr_state_t state_reg;
  logic [31:0] settle_cnt_reg;
  logic standalone_reg;
  logic settled;
  mfr_cfg_t cfg_reg;
  logic [9:0] bus_smp_reg;

  assign settled = (settle_cnt_reg >= SETTLE_CYCLES);

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_STRAP;
      settle_cnt_reg <= 32'h0;
      standalone_reg <= 1'b0;
    end else if (lost_now) begin
      state_reg <= ST_STRAP; // [R13]
      settle_cnt_reg <= 32'h0;
    end else begin
      settle_cnt_reg <= settled ? 32'h0 : settle_cnt_reg + 32'h1;
      case (state_reg)
        ST_STRAP: begin
          if (settled) begin
            standalone_reg <= filt_reg[2]; // [R1]
            state_reg <= filt_reg[2] ? ST_BOOST : ST_RUN;
          end
        end
        ST_BOOST: begin
          if (settled) begin
            state_reg <= ST_RETRY;
          end
        end
        ST_RETRY: begin
          if (settled) begin
            state_reg <= ST_UVWAIT;
          end
        end
        ST_UVWAIT: begin
          if (sample_tick && BUS_VOLTAGE_SENSE > cfg_reg.bus_lo) begin
            state_reg <= ST_RUN; // [R18]
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // strobe pins, driven low while a parameter is read
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BOOST_SELECT_STROBE_O <= 1'b0;
      BOOST_SELECT_STROBE_OE <= 1'b0;
      RETRY_SELECT_STROBE_N <= 1'b1;
    end else begin
      BOOST_SELECT_STROBE_O <= 1'b0;
      BOOST_SELECT_STROBE_OE <= (state_reg == ST_BOOST) && !lost_now; // [R2]
      RETRY_SELECT_STROBE_N <= !((state_reg == ST_RETRY) && !lost_now); // [R8]
    end
  end

  // --------------------------------------------------------------------------
  // configuration: sampled in standalone, written over APB in hosted mode
  // --------------------------------------------------------------------------
  logic wr_en;
  logic [15:0] boost_mul;
  logic [17:0] retry_mul;
  logic [15:0] retry_sa;
  logic [15:0] retry_wr;

  assign wr_en = PSEL && PENABLE && PWRITE && !standalone_reg;
  assign boost_mul = 16'(PARAM_SENSE * `MFR_BOOST_PCT_PER_FS);
  assign retry_mul = 18'(PARAM_SENSE * `MFR_RETRY_Q_PER_FS);
  assign retry_sa = (retry_mul[17:10] < `MFR_RETRY_Q_MIN) ? `MFR_RETRY_Q_MIN : {8'h0, retry_mul[17:10]};
  assign retry_wr = (PWDATA[15:0] < `MFR_RETRY_Q_HOST_MIN) ? `MFR_RETRY_Q_HOST_MIN : PWDATA[15:0];

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_reg.boost_pct <= 7'h0;
      cfg_reg.retry_q <= `MFR_RETRY_Q_MIN;
      cfg_reg.bus_hi <= `MFR_CODE_BUS_HI;
      cfg_reg.bus_lo <= `MFR_CODE_BUS_LO;
      cfg_reg.brake_thr <= `MFR_CODE_BRAKE;
      cfg_reg.onset_thr <= `MFR_CODE_ONSET;
    end else if (state_reg == ST_BOOST && settled) begin
      cfg_reg.boost_pct <= boost_mul[16-1:10] > `MFR_BOOST_PCT_MAX ? `MFR_BOOST_PCT_MAX : 7'(boost_mul[15:10]); // [R3]
    end else if (state_reg == ST_RETRY && settled) begin
      cfg_reg.retry_q <= retry_sa; // [R9]
    end else if (wr_en) begin
      if (PADDR == `MFR_OFS_BOOST) begin
        cfg_reg.boost_pct <= (PWDATA[6:0] > `MFR_BOOST_PCT_HOST_MAX) ? `MFR_BOOST_PCT_HOST_MAX : PWDATA[6:0]; // [R4]
      end else if (PADDR == `MFR_OFS_RETRY) begin
        cfg_reg.retry_q <= retry_wr; // [R10]
      end else if (PADDR == `MFR_OFS_BUS_HI) begin
        cfg_reg.bus_hi <= PWDATA[9:0]; // [R16]
      end else if (PADDR == `MFR_OFS_BUS_LO) begin
        cfg_reg.bus_lo <= PWDATA[9:0]; // [R16]
      end else if (PADDR == `MFR_OFS_BRAKE) begin
        cfg_reg.brake_thr <= PWDATA[9:0]; // [R20]
      end else if (PADDR == `MFR_OFS_ONSET) begin
        cfg_reg.onset_thr <= PWDATA[9:0]; // [R20]
      end
    end
  end

  logic ovr_en_reg;
  logic [15:0] ovr_val_reg;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ovr_en_reg <= 1'b0;
      ovr_val_reg <= 16'h0;
    end else if (wr_en && PADDR == `MFR_OFS_CTRL) begin
      ovr_en_reg <= PWDATA[0];
    end else if (wr_en && PADDR == `MFR_OFS_VOVR) begin
      ovr_val_reg <= PWDATA[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // bus window and brake, evaluated per sample
  // --------------------------------------------------------------------------
  logic bus_bad_reg;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_smp_reg <= 10'h0;
      bus_bad_reg <= 1'b0;
      BRAKE_DRIVE_OUTPUT <= 1'b0;
    end else if (sample_tick) begin
      bus_smp_reg <= BUS_VOLTAGE_SENSE;
      bus_bad_reg <= (BUS_VOLTAGE_SENSE > cfg_reg.bus_hi) || (BUS_VOLTAGE_SENSE < cfg_reg.bus_lo); // [R15]
      BRAKE_DRIVE_OUTPUT <= (BUS_VOLTAGE_SENSE >= cfg_reg.brake_thr); // [R19] [R25]
    end
  end

  // --------------------------------------------------------------------------
  // fault shutdown and retry timer
  // --------------------------------------------------------------------------
  logic fault_now;
  logic [31:0] tick_cnt_reg;
  logic [15:0] retry_cnt_reg;
  logic retry_done;

  assign fault_now = filt_reg[0] || bus_bad_reg || lost_now || (state_reg != ST_RUN);
  assign retry_done = (retry_cnt_reg >= cfg_reg.retry_q);

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PWM_ENABLE <= 1'b0;
      tick_cnt_reg <= 32'h0;
      retry_cnt_reg <= 16'h0;
    end else if (fault_now) begin
      PWM_ENABLE <= 1'b0; // [R7] [R11] [R13]
      tick_cnt_reg <= 32'h0;
      retry_cnt_reg <= 16'h0;
    end else if (!PWM_ENABLE) begin
      if (retry_done) begin
        PWM_ENABLE <= 1'b1; // [R12] [R17]
      end else if (tick_cnt_reg >= RETRY_TICK_CYCLES - 32'h1) begin
        tick_cnt_reg <= 32'h0;
        retry_cnt_reg <= retry_cnt_reg + 16'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // volts-per-hertz amplitude
  // --------------------------------------------------------------------------
  logic [28:0] ratio_full;
  logic [15:0] ratio_q16;
  logic [15:0] boost_q16;
  logic [31:0] slope_prod;
  logic [16:0] amp_sum;

  assign ratio_full = WAVE_FREQ * (BASE_FREQ_60 ? `MFR_RECIP_60HZ : `MFR_RECIP_50HZ);
  assign ratio_q16 = (|ratio_full[28:22]) ? 16'hffff : ratio_full[21:6];
  assign boost_q16 = 16'(cfg_reg.boost_pct * `MFR_PCT_TO_Q16);
  assign slope_prod = (16'hffff - boost_q16) * ratio_q16;
  assign amp_sum = {1'b0, boost_q16} + {1'b0, slope_prod[31:16]};

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      VOLT_AMPLITUDE <= 16'h0;
    end else if (ovr_en_reg && !standalone_reg) begin
      VOLT_AMPLITUDE <= ovr_val_reg; // [R6]
    end else begin
      VOLT_AMPLITUDE <= amp_sum[16] ? 16'hffff : amp_sum[15:0]; // [R5]
    end
  end

  // --------------------------------------------------------------------------
  // deceleration limiting
  // --------------------------------------------------------------------------
  logic [10:0] over_amt;
  logic [9:0] rem_amt;
  logic [25:0] scaled;
  logic [41:0] decel_prod;

  assign over_amt = {1'b0, bus_smp_reg} - {1'b0, cfg_reg.onset_thr}; // [R23]
  assign rem_amt = `MFR_CODE_SPAN - over_amt[9:0];
  assign scaled = ACCEL_RATE * rem_amt;
  assign decel_prod = scaled * `MFR_SPAN_RECIP;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      DECEL_RATE <= 16'h0;
    end else if (!DECELERATING || bus_smp_reg <= cfg_reg.onset_thr) begin
      DECEL_RATE <= ACCEL_RATE; // [R21]
    end else if (over_amt >= {1'b0, `MFR_CODE_SPAN}) begin
      DECEL_RATE <= 16'h0; // [R22]
    end else begin
      DECEL_RATE <= decel_prod[31:16]; // [R24]
    end
  end

  // --------------------------------------------------------------------------
  // APB slave, zero wait states
  // --------------------------------------------------------------------------
  logic mapped;

  always_comb begin
    mapped = 1'b1;
    if (PADDR == `MFR_OFS_CTRL || PADDR == `MFR_OFS_BOOST || PADDR == `MFR_OFS_RETRY) begin
      mapped = 1'b1;
    end else if (PADDR == `MFR_OFS_BUS_HI || PADDR == `MFR_OFS_BUS_LO || PADDR == `MFR_OFS_BRAKE) begin
      mapped = 1'b1;
    end else if (PADDR == `MFR_OFS_ONSET || PADDR == `MFR_OFS_VOVR || PADDR == `MFR_OFS_STATUS) begin
      mapped = 1'b1;
    end else if (PADDR == `MFR_OFS_SAMPLE) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      STANDALONE <= 1'b0;
    end else begin
      PREADY <= 1'b1;
      STANDALONE <= standalone_reg;
      if (PSEL && !PENABLE) begin
        PSLVERR <= !mapped;
        if (PADDR == `MFR_OFS_CTRL) begin
          PRDATA <= {31'h0, ovr_en_reg};
        end else if (PADDR == `MFR_OFS_BOOST) begin
          PRDATA <= {25'h0, cfg_reg.boost_pct};
        end else if (PADDR == `MFR_OFS_RETRY) begin
          PRDATA <= {16'h0, cfg_reg.retry_q};
        end else if (PADDR == `MFR_OFS_BUS_HI) begin
          PRDATA <= {22'h0, cfg_reg.bus_hi};
        end else if (PADDR == `MFR_OFS_BUS_LO) begin
          PRDATA <= {22'h0, cfg_reg.bus_lo};
        end else if (PADDR == `MFR_OFS_BRAKE) begin
          PRDATA <= {22'h0, cfg_reg.brake_thr};
        end else if (PADDR == `MFR_OFS_ONSET) begin
          PRDATA <= {22'h0, cfg_reg.onset_thr};
        end else if (PADDR == `MFR_OFS_VOVR) begin
          PRDATA <= {16'h0, ovr_val_reg};
        end else if (PADDR == `MFR_OFS_STATUS) begin
          PRDATA <= {25'h0, state_reg == ST_RUN, BRAKE_DRIVE_OUTPUT, lost_now, bus_bad_reg,
                     filt_reg[0], PWM_ENABLE, standalone_reg};
        end else if (PADDR == `MFR_OFS_SAMPLE) begin
          PRDATA <= {22'h0, bus_smp_reg};
        end else begin
          PRDATA <= 32'h0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_ext_fault_off;
    @(posedge CORE_CLK) disable iff (SYS_RST) filt_reg[0] |=> !PWM_ENABLE [*2];
  endproperty
  a_ext_fault_off: assert property (p_ext_fault_off) else $error("pwm on during external fault"); // [R11]

  property p_fault_off;
    @(posedge CORE_CLK) disable iff (SYS_RST) (bus_bad_reg || lost_now) |=> !PWM_ENABLE;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("pwm on during fault"); // [R7]

  property p_retry_wait;
    @(posedge CORE_CLK) disable iff (SYS_RST) $rose(PWM_ENABLE) |-> $past(retry_cnt_reg) >= $past(cfg_reg.retry_q);
  endproperty
  a_retry_wait: assert property (p_retry_wait) else $error("pwm back before retry timeout"); // [R12]

  property p_lost_restart;
    @(posedge CORE_CLK) disable iff (SYS_RST) lost_now |=> state_reg == ST_STRAP && !PWM_ENABLE;
  endproperty
  a_lost_restart: assert property (p_lost_restart) else $error("no restart on lost clock"); // [R13]

  property p_window;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      sample_tick ##1 $stable(cfg_reg) |-> bus_bad_reg == (bus_smp_reg > cfg_reg.bus_hi || bus_smp_reg < cfg_reg.bus_lo);
  endproperty
  a_window: assert property (p_window) else $error("bus window flag wrong"); // [R15]

  property p_brake;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      sample_tick ##1 $stable(cfg_reg) |-> BRAKE_DRIVE_OUTPUT == (bus_smp_reg >= cfg_reg.brake_thr);
  endproperty
  a_brake: assert property (p_brake) else $error("brake output wrong"); // [R19]

  property p_decel_full;
    @(posedge CORE_CLK) disable iff (SYS_RST) !DECELERATING |=> DECEL_RATE == $past(ACCEL_RATE);
  endproperty
  a_decel_full: assert property (p_decel_full) else $error("decel rate not accel rate"); // [R21]

  property p_decel_zero;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      DECELERATING && over_amt >= {1'b0, `MFR_CODE_SPAN} && bus_smp_reg > cfg_reg.onset_thr |=> DECEL_RATE == 16'h0;
  endproperty
  a_decel_zero: assert property (p_decel_zero) else $error("decel not zero past span"); // [R22]

  property p_uv_hold;
    @(posedge CORE_CLK) disable iff (SYS_RST) state_reg == ST_UVWAIT |=> !PWM_ENABLE;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("pwm on before bus ready"); // [R18]

  property p_boost_strobe;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      state_reg == ST_BOOST && !lost_now |=> BOOST_SELECT_STROBE_OE && !BOOST_SELECT_STROBE_O;
  endproperty
  a_boost_strobe: assert property (p_boost_strobe) else $error("boost strobe not low"); // [R2]

  property p_boost_limit;
    @(posedge CORE_CLK) disable iff (SYS_RST) standalone_reg && state_reg == ST_RUN |-> cfg_reg.boost_pct <= `MFR_BOOST_PCT_MAX;
  endproperty
  a_boost_limit: assert property (p_boost_limit) else $error("standalone boost over limit"); // [R3]

endmodule : mfr_top

// ===== test/mfr_inv_model.sv
/*
  Behavioural inverter bus-sense path for the motor fault block.
  Assumes the bench commands the bus level; sense follows one cycle late.
*/
`timescale 1ns/1ps
module mfr_inv_model (
  input wire logic clk,
  input wire logic [9:0] level,
  output logic [9:0] bus_sense = 10'h2cc
);
  // --------------------------------------------------------------------------
  // sense code lags the commanded capacitor level
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    bus_sense <= level;
  end
endmodule : mfr_inv_model

// ===== test/mfr_top_tb_top.sv
/*
  Self-checking bench for mfr_top in hosted mode, then standalone after a second reset.
  Assumes shortened sample and retry counts; reads checked by a queue monitor.
*/
`timescale 1ns/1ps
module mfr_top_tb_top;
  import mfr_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rck = 0, flt = 0, dec = 0;
  logic strap = 0, p15 = 0, b60 = 0, ron = 1;
  logic pready, perr, pwm, brk, sa, so, soe, rsn;
  logic [7:0] pa = '0;
  logic [31:0] pwd = '0, prd;
  logic [9:0] lvl = 10'h2cc, bus, prm = '0;
  logic [9:0] lv[4] = '{10'h314, 10'h320, 10'h393, 10'h300};
  logic [15:0] acc = '0, drate, wf = '0, amp, vo;
  logic [32:0] exp_q[$];
  longint ov, e;
  int n_mismatch = 0, cmp_count = 0;
  always #5 clk = ~clk;
  always #2000 if (ron) rck = ~rck;
  mfr_inv_model mfr_inv_model_i (.clk(clk), .level(lvl), .bus_sense(bus));
  mfr_top #(.SAMPLE_DIV_FAST(20), .SAMPLE_DIV_SLOW(30), .RETRY_TICK_CYCLES(10),
    .LOSTCLK_CYCLES(1000), .SETTLE_CYCLES(100)) mfr_top_i (
    .CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr),
    .BOOST_SELECT_STROBE_I(strap), .BOOST_SELECT_STROBE_O(so), .BOOST_SELECT_STROBE_OE(soe),
    .RETRY_SELECT_STROBE_N(rsn), .PARAM_SENSE(prm), .BUS_VOLTAGE_SENSE(bus),
    .EXTERNAL_FAULT_INPUT(flt), .REFERENCE_CLOCK_INPUT(rck), .PWM_FREQ_15K9(p15),
    .BASE_FREQ_60(b60), .WAVE_FREQ(wf), .DECELERATING(dec), .ACCEL_RATE(acc),
    .PWM_ENABLE(pwm), .BRAKE_DRIVE_OUTPUT(brk), .VOLT_AMPLITUDE(amp), .DECEL_RATE(drate),
    .STANDALONE(sa));
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic wait_sig(ref logic s, input logic v);
    for (int n = 0; s !== v; n++) begin
      if (n == 500) begin
        n_mismatch++;
        finish_test();
      end
      @(posedge clk);
    end
  endtask : wait_sig
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex);
    if (!w) exp_q.push_back(ex);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    wait_sig(pready, 1'b1);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask : apb
  // --------------------------------------------------------------------------
  // monitor: oldest queued read result against the completed access
  // --------------------------------------------------------------------------
  always @(posedge clk) if (psel && pen && pready && !pwr) chk("prdata", {perr, prd}, exp_q.pop_front());
  initial begin
    void'($urandom(40534));
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (130) @(posedge clk);
    chk("standalone", sa, 0);
    apb(1, 8'h04, 32'h7f, 0);
    apb(0, 8'h04, 0, 33'h64);
    apb(1, 8'h0c, 32'h3ff, 0);
    apb(0, 8'h0c, 0, 33'h3ff);
    apb(0, 8'h40, 0, 33'h100000000);
    apb(1, 8'h14, 32'h320, 0);
    b60 <= 1'($urandom);
    vo = 16'($urandom);
    @(posedge clk);
    chk("amp", amp >= 16'hff00, 1);
    apb(1, 8'h1c, vo, 0);
    apb(1, 8'h00, 32'h1, 0);
    @(posedge clk);
    chk("amp", amp, vo);
    apb(1, 8'h00, 32'h0, 0);
    apb(1, 8'h04, 32'h0, 0);
    wf <= b60 ? 16'h1e0 : 16'h190;
    repeat (2) @(posedge clk);
    chk("amp", amp > 16'h7f00 && amp < 16'h8100, 1);
    apb(1, 8'h08, 32'h1, 0);
    wait_sig(pwm, 1'b1);
    flt <= 1;
    repeat (8) @(posedge clk);
    chk("pwm", pwm, 0);
    flt <= 0;
    repeat (4) @(posedge clk);
    chk("pwm", pwm, 0);
    wait_sig(pwm, 1'b1);
    lvl <= 10'h100;
    repeat (50) @(posedge clk);
    chk("pwm", pwm, 0);
    lvl <= 10'h2cc;
    wait_sig(pwm, 1'b1);
    acc <= 16'($urandom);
    p15 <= 1;
    dec <= 1;
    foreach (lv[i]) begin
      lvl <= lv[i];
      repeat (50) @(posedge clk);
      ov = longint'(lv[i]) - 788;
      e = ov <= 0 ? acc : ov >= 127 ? 0 : (longint'(acc) * (127 - ov) * 516) >> 16;
      chk("brake", brk, lv[i] >= 10'h320);
      chk("decel", drate, 33'(e));
    end
    ron <= 0;
    repeat (700) @(posedge clk);
    wait_sig(pwm, 1'b0);
    ron <= 1;
    repeat (50) @(posedge clk);
    chk("pwm", pwm, 0);
    strap <= 1;
    prm <= 10'($urandom);
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    wait_sig(sa, 1'b1);
    repeat (5) @(posedge clk);
    chk("strobe", {soe, so}, 2'b10);
    repeat (100) @(posedge clk);
    chk("strobe", rsn, 0);
    repeat (140) @(posedge clk);
    e = (longint'(prm) * 240) >> 10;
    apb(1, 8'h04, 32'h10, 0);
    apb(0, 8'h04, 0, 33'((longint'(prm) * 40) >> 10));
    apb(0, 8'h08, 0, 33'(e < 4 ? 4 : e));
    finish_test();
  end
endmodule : mfr_top_tb_top
